// >>> pkg/lco_pkg.sv
// ----------------------------------------------------------------
// Cursor and overlay configuration constants
// ----------------------------------------------------------------
package lco_pkg;

  // Register byte addresses on the host bus
  localparam logic [15:0] ADDR_CURSOR_WIDTH = 16'h8015;
  localparam logic [15:0] ADDR_CURSOR_HEIGHT = 16'h8016;
  localparam logic [15:0] ADDR_CURSOR_DIR = 16'h8017;
  localparam logic [15:0] ADDR_LAYER_OVERLAY = 16'h8018;

  // Reset values
  localparam logic [7:0] RST_CURSOR_WIDTH = 8'h00;
  localparam logic [7:0] RST_CURSOR_HEIGHT = 8'h00;
  localparam logic [7:0] RST_CURSOR_DIR = 8'h00;
  localparam logic [7:0] RST_LAYER_OVERLAY = 8'h00;

  // Field positions
  localparam int CURSOR_FIELD_MSB = 3;
  localparam int CURSOR_SHAPE_BIT = 7;
  localparam int DIR_MSB = 1;
  localparam int OVL_THREE_LAYER_BIT = 4;
  localparam int OVL_BLOCK3_GFX_BIT = 3;
  localparam int OVL_BLOCK1_GFX_BIT = 2;
  localparam int OVL_METHOD_MSB = 1;
  localparam int OVL_MSB = 4;

  // Indirect command codes; movement codes share the upper six bits
  localparam logic [5:0] CMD_MOVE_HI = 6'h13;
  localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h60;
  localparam logic [7:0] CMD_LAYER_COMPOSE = 8'h61;

  // Cursor movement directions
  typedef enum logic [1:0] {
    LCO_DIR_RIGHT = 2'b00,
    LCO_DIR_LEFT = 2'b01,
    LCO_DIR_UP = 2'b10,
    LCO_DIR_DOWN = 2'b11
  } lco_dir_t;

  // Layer combination methods
  localparam logic [1:0] METHOD_RESERVED = 2'b11;

  // Indirect parameter sequencer states
  typedef enum logic [1:0] {
    LCO_ST_IDLE = 2'b00,
    LCO_ST_SHAPE_W = 2'b01,
    LCO_ST_SHAPE_H = 2'b10,
    LCO_ST_OVLY = 2'b11
  } lco_state_t;

endpackage : lco_pkg

// >>> rtl/lco_addr_step.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Automatic cursor address step
// ----------------------------------------------------------------
module lco_addr_step #(
  parameter int AW = 16
) (
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] dir,
  input wire logic [AW-1:0] pitch,
  output logic [AW-1:0] next_addr
);

  // Horizontal moves one address unit even with 9-pixel characters
  always_comb begin
    case (dir)
      lco_pkg::LCO_DIR_RIGHT: next_addr = addr + AW'(1);
      lco_pkg::LCO_DIR_LEFT: next_addr = addr - AW'(1);
      lco_pkg::LCO_DIR_UP: next_addr = addr - pitch;
      default: next_addr = addr + pitch;
    endcase
  end

endmodule : lco_addr_step

// >>> rtl/lco_blank.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Derived block sizes and dual panel blanking
// ----------------------------------------------------------------
module lco_blank #(
  parameter int LW = 8
) (
  input wire logic [LW-1:0] lines_per_frame,
  input wire logic [LW-1:0] sl1,
  input wire logic [LW-1:0] sl2,
  input wire logic dual_panel,
  output logic [LW-1:0] sl3,
  output logic [LW-1:0] sl4,
  output logic [LW-1:0] blank1,
  output logic [LW-1:0] blank2
);

  logic [LW:0] half;

  // Block 3 follows the shorter block, block 4 the frame
  always_comb begin
    sl3 = (sl1 < sl2) ? sl1 : sl2;
    sl4 = lines_per_frame;
    half = ({1'b0, lines_per_frame} + (LW+1)'(1)) >> 1;
    blank1 = '0;
    blank2 = '0;
    // Shortfall only matters when the panel is split
    if (dual_panel && (half > {1'b0, sl1})) begin
      blank1 = LW'(half - {1'b0, sl1});
    end
    if (dual_panel && (half > {1'b0, sl2})) begin
      blank2 = LW'(half - {1'b0, sl2});
    end
  end

endmodule : lco_blank

// >>> rtl/lco_top.sv
`timescale 1ns/1ps
module lco_top #(
  parameter int AW = 16,
  parameter int LW = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic indirect_mode,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic param_valid,
  input wire logic [7:0] param_data,
  input wire logic [LW-1:0] lines_per_frame,
  input wire logic [LW-1:0] block1_line_count,
  input wire logic [LW-1:0] block2_line_count,
  input wire logic dual_panel,
  input wire logic [AW-1:0] addr_pitch,
  input wire logic cursor_load,
  input wire logic [AW-1:0] cursor_load_addr,
  input wire logic mem_access,
  output logic [3:0] cursor_width_field,
  output logic [3:0] cursor_height_field,
  output logic cursor_shape_bit,
  output logic [1:0] cursor_dir,
  output logic three_layer_select,
  output logic block3_graphics_select,
  output logic block1_graphics_select,
  output logic [1:0] layer_combine_method,
  output logic combine_reserved,
  output logic [LW-1:0] block3_line_count,
  output logic [LW-1:0] block4_line_count,
  output logic [LW-1:0] block1_blank_lines,
  output logic [LW-1:0] block2_blank_lines,
  output logic [AW-1:0] cursor_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lco_pkg::lco_state_t st;
    logic [3:0] width;
    logic [3:0] height;
    logic shape;
    logic [1:0] dir;
    logic [lco_pkg::OVL_MSB:0] ovl;
    logic reserved;
    logic [7:0] rdata;
    logic [AW-1:0] caddr;
    logic [LW-1:0] sl3;
    logic [LW-1:0] sl4;
    logic [LW-1:0] blank1;
    logic [LW-1:0] blank2;
  } lco_regs_t;

  lco_regs_t state_reg;
  lco_regs_t state_next;
  logic [AW-1:0] step_addr;
  logic [LW-1:0] sl3_w;
  logic [LW-1:0] sl4_w;
  logic [LW-1:0] blank1_w;
  logic [LW-1:0] blank2_w;

  // Address decode used by both write and read paths
  function automatic logic [2:0] lco_decode(input logic [15:0] a);
    if (a == lco_pkg::ADDR_CURSOR_WIDTH) begin
      lco_decode = 3'h1;
    end else if (a == lco_pkg::ADDR_CURSOR_HEIGHT) begin
      lco_decode = 3'h2;
    end else if (a == lco_pkg::ADDR_CURSOR_DIR) begin
      lco_decode = 3'h3;
    end else if (a == lco_pkg::ADDR_LAYER_OVERLAY) begin
      lco_decode = 3'h4;
    end else begin
      lco_decode = 3'h0;
    end
  endfunction : lco_decode

  logic [2:0] sel;
  logic is_move_cmd;

  assign sel = lco_decode(bus_addr);
  assign is_move_cmd = indirect_mode && cmd_valid &&
    (cmd_code[7:2] == lco_pkg::CMD_MOVE_HI);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  lco_addr_step #(
    .AW(AW)
  ) u_step (
    .addr(state_reg.caddr),
    .dir(state_reg.dir),
    .pitch(addr_pitch),
    .next_addr(step_addr)
  );

  lco_blank #(
    .LW(LW)
  ) u_blank (
    .lines_per_frame(lines_per_frame),
    .sl1(block1_line_count),
    .sl2(block2_line_count),
    .dual_panel(dual_panel),
    .sl3(sl3_w),
    .sl4(sl4_w),
    .blank1(blank1_w),
    .blank2(blank2_w)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Indirect parameters come after bus writes so they win a collision
  always_comb begin
    state_next = state_reg;
    state_next.sl3 = sl3_w;
    state_next.sl4 = sl4_w;
    state_next.blank1 = blank1_w;
    state_next.blank2 = blank2_w;

    // Direct register writes; unused bits are not stored
    if (bus_wr) begin
      if (sel == 3'h1) begin
        state_next.width = bus_wdata[lco_pkg::CURSOR_FIELD_MSB:0];
      end else if (sel == 3'h2) begin
        state_next.shape = bus_wdata[lco_pkg::CURSOR_SHAPE_BIT];
        state_next.height = bus_wdata[lco_pkg::CURSOR_FIELD_MSB:0];
      end else if (sel == 3'h3) begin
        state_next.dir = bus_wdata[lco_pkg::DIR_MSB:0];
      end else if (sel == 3'h4) begin
        state_next.ovl = bus_wdata[lco_pkg::OVL_MSB:0];
      end
    end

    // Read data registered; unmapped addresses read zero
    state_next.rdata = 8'h00;
    if (bus_rd) begin
      if (sel == 3'h1) begin
        state_next.rdata = {4'h0, state_reg.width};
      end else if (sel == 3'h2) begin
        state_next.rdata = {state_reg.shape, 3'h0, state_reg.height};
      end else if (sel == 3'h3) begin
        state_next.rdata = {6'h00, state_reg.dir};
      end else if (sel == 3'h4) begin
        state_next.rdata = {3'h0, state_reg.ovl};
      end
    end

    // Indirect parameter sequencer
    case (state_reg.st)
      lco_pkg::LCO_ST_SHAPE_W: begin
        if (param_valid) begin
          state_next.width = param_data[lco_pkg::CURSOR_FIELD_MSB:0];
          state_next.st = lco_pkg::LCO_ST_SHAPE_H;
        end
      end
      lco_pkg::LCO_ST_SHAPE_H: begin
        if (param_valid) begin
          state_next.shape = param_data[lco_pkg::CURSOR_SHAPE_BIT];
          state_next.height = param_data[lco_pkg::CURSOR_FIELD_MSB:0];
          state_next.st = lco_pkg::LCO_ST_IDLE;
        end
      end
      lco_pkg::LCO_ST_OVLY: begin
        if (param_valid) begin
          state_next.ovl = param_data[lco_pkg::OVL_MSB:0];
          state_next.st = lco_pkg::LCO_ST_IDLE;
        end
      end
      default: begin
        state_next.st = lco_pkg::LCO_ST_IDLE;
      end
    endcase

    // A new command aborts any unfinished parameter list
    if (indirect_mode && cmd_valid) begin
      if (cmd_code == lco_pkg::CMD_CURSOR_SHAPE) begin
        state_next.st = lco_pkg::LCO_ST_SHAPE_W;
      end else if (cmd_code == lco_pkg::CMD_LAYER_COMPOSE) begin
        state_next.st = lco_pkg::LCO_ST_OVLY;
      end else begin
        state_next.st = lco_pkg::LCO_ST_IDLE;
      end
    end
    // Direction rides in the low two bits of the code
    if (is_move_cmd) begin
      state_next.dir = cmd_code[lco_pkg::DIR_MSB:0];
    end

    // Cursor address: an explicit load beats the automatic step
    if (cursor_load) begin
      state_next.caddr = cursor_load_addr;
    end else if (mem_access) begin
      state_next.caddr = step_addr;
    end

    // Reserved method flag kept in its own flop so the output is clean
    state_next.reserved =
      &state_next.ovl[lco_pkg::OVL_METHOD_MSB:0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg.st <= lco_pkg::LCO_ST_IDLE;
      state_reg.width <=
        lco_pkg::RST_CURSOR_WIDTH[lco_pkg::CURSOR_FIELD_MSB:0];
      state_reg.height <=
        lco_pkg::RST_CURSOR_HEIGHT[lco_pkg::CURSOR_FIELD_MSB:0];
      state_reg.shape <= lco_pkg::RST_CURSOR_HEIGHT[lco_pkg::CURSOR_SHAPE_BIT];
      state_reg.dir <= lco_pkg::RST_CURSOR_DIR[lco_pkg::DIR_MSB:0];
      state_reg.ovl <= lco_pkg::RST_LAYER_OVERLAY[lco_pkg::OVL_MSB:0];
      state_reg.reserved <=
        &lco_pkg::RST_LAYER_OVERLAY[lco_pkg::OVL_METHOD_MSB:0];
      state_reg.rdata <= 8'h00;
      state_reg.caddr <= '0;
      state_reg.sl3 <= '0;
      state_reg.sl4 <= '0;
      state_reg.blank1 <= '0;
      state_reg.blank2 <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fields of the layer register drive composition directly
  assign bus_rdata = state_reg.rdata;
  assign cursor_width_field = state_reg.width;
  assign cursor_height_field = state_reg.height;
  assign cursor_shape_bit = state_reg.shape;
  assign cursor_dir = state_reg.dir;
  assign three_layer_select =
    state_reg.ovl[lco_pkg::OVL_THREE_LAYER_BIT];
  assign block3_graphics_select =
    state_reg.ovl[lco_pkg::OVL_BLOCK3_GFX_BIT];
  assign block1_graphics_select =
    state_reg.ovl[lco_pkg::OVL_BLOCK1_GFX_BIT];
  assign layer_combine_method =
    state_reg.ovl[lco_pkg::OVL_METHOD_MSB:0];
  // Reserved method flag straight from its flop
  assign combine_reserved = state_reg.reserved;
  assign block3_line_count = state_reg.sl3;
  assign block4_line_count = state_reg.sl4;
  assign block1_blank_lines = state_reg.blank1;
  assign block2_blank_lines = state_reg.blank2;
  assign cursor_addr = state_reg.caddr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_move_cmd_dir: assert property (
    is_move_cmd |=> cursor_dir == $past(cmd_code[1:0]))
    else $error("move command did not set direction");

  a_shape_params: assert property (
    (indirect_mode && cmd_valid && cmd_code == lco_pkg::CMD_CURSOR_SHAPE)
    ##1 (param_valid && !cmd_valid)[*1] ##1 (param_valid && !cmd_valid)
    |=> cursor_width_field == $past(param_data[3:0], 2) &&
        cursor_height_field == $past(param_data[3:0]) &&
        cursor_shape_bit == $past(param_data[7]))
    else $error("shape parameters not loaded in order");

  a_ovl_param: assert property (
    (indirect_mode && cmd_valid && cmd_code == lco_pkg::CMD_LAYER_COMPOSE)
    ##1 (param_valid && !cmd_valid)
    |=> {three_layer_select, block3_graphics_select,
         block1_graphics_select, layer_combine_method}
        == $past(param_data[4:0]))
    else $error("overlay parameter not loaded");

  a_block3_min: assert property (
    $past(rstn) |-> block3_line_count ==
      (($past(block1_line_count) < $past(block2_line_count)) ?
        $past(block1_line_count) : $past(block2_line_count)))
    else $error("block 3 size not the smaller block");

  a_block4_frame: assert property (
    $past(rstn) |-> block4_line_count == $past(lines_per_frame))
    else $error("block 4 size not from frame lines");

  a_blank_single: assert property (
    !dual_panel |=> block1_blank_lines == '0 && block2_blank_lines == '0)
    else $error("blanking without dual panel");

  a_blank_dual: assert property (
    dual_panel |=> (block1_blank_lines + $past(block1_line_count) ==
      LW'(({1'b0, $past(lines_per_frame)} + (LW+1)'(1)) >> 1)) ||
      (block1_blank_lines == '0 && $past(block1_line_count) >=
      LW'(({1'b0, $past(lines_per_frame)} + (LW+1)'(1)) >> 1)))
    else $error("dual panel blank count wrong");

  a_step_down: assert property (
    mem_access && !cursor_load && cursor_dir == lco_pkg::LCO_DIR_DOWN &&
    !is_move_cmd |=> cursor_addr == $past(cursor_addr) + $past(addr_pitch))
    else $error("down step not by pitch");

  a_step_right: assert property (
    mem_access && !cursor_load && cursor_dir == lco_pkg::LCO_DIR_RIGHT
    |=> cursor_addr == $past(cursor_addr) + AW'(1))
    else $error("right step not by one");

  a_width_write: assert property (
    bus_wr && bus_addr == lco_pkg::ADDR_CURSOR_WIDTH &&
    state_reg.st != lco_pkg::LCO_ST_SHAPE_W
    |=> cursor_width_field == $past(bus_wdata[3:0]))
    else $error("width write lost");

  a_hold_idle: assert property (
    !bus_wr && state_reg.st == lco_pkg::LCO_ST_IDLE
    |=> $stable(cursor_shape_bit))
    else $error("shape changed without a write");

  c_shape_cmd: cover property (
    state_reg.st == lco_pkg::LCO_ST_SHAPE_H && param_valid);
  c_move_up: cover property (
    is_move_cmd && cmd_code[1:0] == lco_pkg::LCO_DIR_UP);
  c_dual_blank: cover property (block1_blank_lines != '0);
  c_three_layer: cover property (three_layer_select && !combine_reserved);

endmodule : lco_top

// >>> sim/lcd_cursor_overlay_config_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench: expectations queued, compared by a monitor
// ----------------------------------------------------------------
module lcd_cursor_overlay_config_test;
  typedef struct packed {logic [3:0] kind; logic [15:0] val;} lco_note_t;
  logic clock, rstn, indirect_mode, dual_panel, look;
  logic [7:0] lines_per_frame, block1_line_count, block2_line_count;
  logic [15:0] addr_pitch, bus_addr, cursor_load_addr, caddr, a, e;
  logic bus_wr, bus_rd, cmd_valid, param_valid, cursor_load, mem_access;
  logic [7:0] bus_wdata, bus_rdata, cmd_code, param_data, d, h, s1, s2;
  logic [3:0] cw, chf;
  logic [1:0] cdir, lcm;
  logic csh, tl, b3g, b1g, crs;
  logic [7:0] sl3, sl4, bl1, bl2;
  lco_note_t notes[$];
  lco_note_t cur;
  int mismatches = 0;
  int tests_run = 0;

  lco_host u_lco_host (.clock(clock), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .param_valid(param_valid), .param_data(param_data),
    .cursor_load(cursor_load), .cursor_load_addr(cursor_load_addr),
    .mem_access(mem_access));

  lco_top u_lco_top (.clock(clock), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .indirect_mode(indirect_mode),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_valid(param_valid),
    .param_data(param_data), .lines_per_frame(lines_per_frame),
    .block1_line_count(block1_line_count),
    .block2_line_count(block2_line_count), .dual_panel(dual_panel),
    .addr_pitch(addr_pitch), .cursor_load(cursor_load),
    .cursor_load_addr(cursor_load_addr), .mem_access(mem_access),
    .cursor_width_field(cw), .cursor_height_field(chf),
    .cursor_shape_bit(csh), .cursor_dir(cdir), .three_layer_select(tl),
    .block3_graphics_select(b3g), .block1_graphics_select(b1g),
    .layer_combine_method(lcm), .combine_reserved(crs),
    .block3_line_count(sl3), .block4_line_count(sl4),
    .block1_blank_lines(bl1), .block2_blank_lines(bl2), .cursor_addr(caddr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Observed value picked by kind of note
  function automatic logic [15:0] obs(input logic [3:0] k);
    case (k)
      4'd0: obs = {8'h00, bus_rdata};
      4'd1: obs = {12'h000, cw};
      4'd2: obs = {11'h000, csh, chf};
      4'd4: obs = {14'h0000, cdir};
      4'd5: obs = {10'h000, tl, b3g, b1g, lcm, crs};
      4'd6: obs = {8'h00, sl3};
      4'd7: obs = {8'h00, sl4};
      4'd8: obs = {8'h00, bl1};
      4'd9: obs = {8'h00, bl2};
      default: obs = caddr;
    endcase
  endfunction : obs

  // Overlay outputs expected from an overlay byte
  function automatic logic [15:0] ovx(input logic [7:0] v);
    ovx = {10'h000, v[4:2], v[1:0], &v[1:0]};
  endfunction : ovx

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Queue a note; the monitor compares at the next edge
  task automatic note(input logic [3:0] k, input logic [15:0] v);
    notes.push_back({k, v});
    look = 1'b1;
    @(posedge clock);
    #1;
    look = 1'b0;
  endtask : note

  task automatic rd_exp(input logic [15:0] ad, input logic [7:0] v);
    u_lco_host.rd(ad);
    note(4'd0, {8'h00, v});
  endtask : rd_exp

  // Monitor: registered results settle one edge after their cause
  always @(posedge clock) begin
    if (look) begin
      cur = notes.pop_front();
      check(obs(cur.kind), cur.val);
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog sized well beyond the under two hundred cycles of the tests
  initial begin
    #(5000 * 50);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, indirect_mode, dual_panel, look} = '0;
    {lines_per_frame, block1_line_count, block2_line_count} = '0;
    addr_pitch = 16'h0000;
    void'($urandom(32'hc50d));
    // Level inputs random from the start so nothing sits at a constant
    lines_per_frame = 8'($urandom);
    block1_line_count = 8'($urandom);
    block2_line_count = 8'($urandom);
    dual_panel = 1'($urandom);
    addr_pitch = 16'($urandom);
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    // Reset values, unmapped address reads zero
    for (int i = 0; i < 5; i++) rd_exp(16'h8015 + 16'(i), 8'h00);
    $display("test reset done");
    // Direct writes, unused bits read back as zero
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      u_lco_host.wr(16'h8015, d);
      rd_exp(16'h8015, {4'h0, d[3:0]});
      u_lco_host.wr(16'h8016, d);
      note(4'd2, {11'h000, d[7], d[3:0]});
      rd_exp(16'h8016, {d[7], 3'h0, d[3:0]});
      d[1:0] = 2'(i);
      u_lco_host.wr(16'h8018, d);
      note(4'd5, ovx(d));
      rd_exp(16'h8018, {3'h0, d[4:0]});
      u_lco_host.wr(16'h8017, d);
      rd_exp(16'h8017, {6'h00, d[1:0]});
    end
    u_lco_host.wr(16'h8015, 8'h05);
    u_lco_host.hold();
    u_lco_host.wr(16'h8019, 8'hff);
    rd_exp(16'h8019, 8'h00);
    rd_exp(16'h8015, 8'h05);
    $display("test registers done");
    // Indirect shape and overlay, abort and stray parameter
    indirect_mode = 1'b1;
    d = 8'($urandom % 8);
    h = {1'($urandom), 4'h0, 3'($urandom)};
    u_lco_host.form(d, h);
    note(4'd1, {12'h000, d[3:0]});
    note(4'd2, {11'h000, h[7], h[3:0]});
    d = {3'b000, 1'($urandom), 1'($urandom), 1'b1, 2'($urandom)};
    u_lco_host.ovl(d);
    note(4'd5, ovx(d));
    // Graphics now on block 1, so the host forces the block cursor
    u_lco_host.form(8'h03, 8'h02);
    note(4'd1, 16'h0003);
    note(4'd2, 16'h0012);
    u_lco_host.cmd(8'h60);
    u_lco_host.prm(8'h02);
    u_lco_host.cmd(8'h61);
    u_lco_host.prm(8'h01);
    u_lco_host.hold();
    u_lco_host.prm(8'h0f);
    note(4'd1, 16'h0002);
    note(4'd2, 16'h0012);
    note(4'd5, ovx(8'h01));
    $display("test indirect done");
    // Movement commands and address stepping per direction
    addr_pitch = 16'($urandom);
    for (int i = 0; i < 4; i++) begin
      u_lco_host.cmd(8'h4c + 8'(i));
      note(4'd4, 16'(i));
      a = 16'($urandom);
      u_lco_host.ld(a);
      u_lco_host.acc();
      e = (i == 0) ? a + 16'h0001 : (i == 1) ? a - 16'h0001 :
          (i == 2) ? a - addr_pitch : a + addr_pitch;
      note(4'd10, e);
    end
    indirect_mode = 1'b0;
    u_lco_host.cmd(8'h4c);
    note(4'd4, 16'h0003);
    $display("test cursor done");
    // Derived block sizes and dual panel blanking
    for (int i = 0; i < 8; i++) begin
      lines_per_frame = 8'($urandom % 255);
      s1 = (i == 2) ? 8'h00 : 8'($urandom % 160);
      s2 = 8'($urandom % 160);
      block1_line_count = s1;
      block2_line_count = s2;
      dual_panel = ~i[0];
      h = 8'((9'(lines_per_frame) + 9'd1) >> 1);
      @(posedge clock);
      #1;
      note(4'd6, {8'h00, (s1 < s2) ? s1 : s2});
      note(4'd7, {8'h00, lines_per_frame});
      note(4'd8, {8'h00, (dual_panel && h > s1) ? h - s1 : 8'h00});
      note(4'd9, {8'h00, (dual_panel && h > s2) ? h - s2 : 8'h00});
    end
    $display("test sizes done");
    wrap_up();
  end
endmodule : lcd_cursor_overlay_config_test

// >>> sim/lco_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor model: register bus, commands, memory accesses
// ----------------------------------------------------------------
module lco_host #(
  parameter int CHAR_W = 8,
  parameter int CHAR_H = 8
) (
  input wire logic clock,
  output logic [15:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic param_valid,
  output logic [7:0] param_data,
  output logic cursor_load,
  output logic [15:0] cursor_load_addr,
  output logic mem_access
);
  logic gfx;

  // Idle levels at time zero
  initial begin
    {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
    {cmd_valid, cmd_code, param_valid, param_data} = '0;
    {cursor_load, cursor_load_addr, mem_access, gfx} = '0;
  end

  // One strobe cycle; every request ends just after the next edge
  task automatic hold;
    @(posedge clock);
    #1;
  endtask : hold

  // Released data lines show the inverse, never the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    hold();
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    hold();
    bus_rd = 1'b0;
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    cmd_code = c;
    cmd_valid = 1'b1;
    hold();
    cmd_valid = 1'b0;
    cmd_code = ~c;
  endtask : cmd

  task automatic prm(input logic [7:0] d);
    param_data = d;
    param_valid = 1'b1;
    hold();
    param_valid = 1'b0;
    param_data = ~d;
  endtask : prm

  // Two parameters back to back; the strobe stays up between them
  task automatic prm2(input logic [7:0] d0, input logic [7:0] d1);
    param_data = d0;
    param_valid = 1'b1;
    hold();
    param_data = d1;
    hold();
    param_valid = 1'b0;
    param_data = ~d1;
  endtask : prm2

  // Cursor shape command; sizes kept within the character cell
  task automatic form(input logic [7:0] w, input logic [7:0] h);
    if (w[3:0] > CHAR_W - 1) w[3:0] = 4'(CHAR_W - 1);
    if (h[3:0] > CHAR_H - 1) h[3:0] = 4'(CHAR_H - 1);
    if (gfx) h[7] = 1'b1;
    cmd(8'h60);
    prm2(w, h);
  endtask : form

  // Overlay command; three layers only without text on block 1
  task automatic ovl(input logic [7:0] d);
    if (!d[2]) d[4] = 1'b0;
    gfx = d[2];
    cmd(8'h61);
    prm(d);
  endtask : ovl

  task automatic ld(input logic [15:0] a);
    cursor_load_addr = a;
    cursor_load = 1'b1;
    hold();
    cursor_load = 1'b0;
    cursor_load_addr = ~a;
  endtask : ld

  task automatic acc;
    mem_access = 1'b1;
    hold();
    mem_access = 1'b0;
  endtask : acc
endmodule : lco_host
